// file: common/pct_pkg.sv
// Purpose: Shared constants and types for the cable test and power block
// Assumes: 100 MHz system clock, 16-bit management registers
// Notes:   Register numbers are 5-bit management addresses
package pct_pkg;

	// ----------------------------------------------------------------
	// Register numbers
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_BASIC_CTRL  = 5'h00;
	localparam logic [4:0] REG_DIGI_CTRL   = 5'h10;
	localparam logic [4:0] REG_AFE_CTRL    = 5'h11;
	localparam logic [4:0] REG_OPMODE_OVR  = 5'h16;
	localparam logic [4:0] REG_EXP_CTRL    = 5'h18;
	localparam logic [4:0] REG_CABLE_TEST  = 5'h1d;
	localparam logic [4:0] REG_PHY_CTRL2   = 5'h1f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_SW_RESET  = 15;
	localparam int BIT_AN_EN     = 12;
	localparam int BIT_PWR_DOWN  = 11;
	localparam int BIT_PLL_OFF   = 4;
	localparam int BIT_SLOW_OSC  = 5;
	localparam int BIT_BCAST_OFF = 9;
	localparam int BIT_NAND_EN   = 5;
	localparam int BIT_ENERGY_DETECT_POWER_DOWN_DIS  = 11;
	localparam int BIT_CT_START  = 15;
	localparam int CT_RES_LSB    = 13;
	localparam int CT_DIST_MSB   = 8;
	localparam int BIT_MDIX_SEL  = 14;
	localparam int BIT_AMDIX_DIS = 13;
	localparam int BIT_PWR_SAVE  = 10;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic RST_AN_EN    = 1'h1;
	localparam logic RST_ENERGY_DETECT_POWER_DOWN_DIS = 1'h1;

	// ----------------------------------------------------------------
	// Cable test outcome codes and distance range
	// ----------------------------------------------------------------
	localparam logic [1:0] CT_NORMAL  = 2'h0;
	localparam logic [1:0] CT_OPEN    = 2'h1;
	localparam logic [1:0] CT_SHORT   = 2'h2;
	localparam logic [1:0] CT_INVALID = 2'h3;
	localparam logic [8:0] DIST_MAX   = 9'h1ff;

	// ----------------------------------------------------------------
	// Management frame layout
	// ----------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST     = 5'h0c;
	localparam logic [4:0] DATA_LAST    = 5'h0f;
	localparam logic [4:0] DATA_BITS    = 5'h10;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_WRITE     = 2'h1;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TDR_PULSE_NS    = 40;
	localparam int TDR_PULSE_CYC   =
		(TDR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SILENCE_WAIT_US = 2000;
	localparam int SILENCE_CYC     =
		SILENCE_WAIT_US * 1000 / CLK_PERIOD_NS;
	localparam int LP_INTERVAL_US  = 16000;
	localparam int LP_CYC          =
		LP_INTERVAL_US * 1000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MS_IDLE, MS_HDR, MS_TA, MS_RD, MS_WTA, MS_WR
	} pct_mstate_t;

	typedef enum logic [1:0] {
		CS_IDLE, CS_SILENCE, CS_PULSE, CS_LISTEN
	} pct_cstate_t;

endpackage

// file: src/pct_cable_engine.sv
// Purpose: Reflectometry run sequencer: silence, pulse, listen, report
// Assumes: Echo inputs already synchronised by the caller
// Notes:   Results change only when a run finishes
`timescale 1ns/1ps
`default_nettype none
module pct_cable_engine #(
	parameter int unsigned SILENCE_CYC = pct_pkg::SILENCE_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_start,
	input  wire logic       i_partner_quiet,
	input  wire logic       i_echo_seen,
	input  wire logic       i_echo_short,
	output logic            o_busy,
	output logic            o_quiet_req,
	output logic            o_pulse,
	output logic [1:0]      o_result,
	output logic [8:0]      o_distance
);

	pct_pkg::pct_cstate_t st_q;
	logic [31:0]          tmr_q;
	logic [8:0]           dcnt_q;

	// ----------------------------------------------------------------
	// Run sequencer
	// ----------------------------------------------------------------
	// Results are written only on the finishing cycle, never mid-run
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_q        <= pct_pkg::CS_IDLE;
			tmr_q       <= 32'h0;
			dcnt_q      <= 9'h0;
			o_busy      <= 1'b0;
			o_quiet_req <= 1'b0;
			o_pulse     <= 1'b0;
			o_result    <= pct_pkg::CT_NORMAL;
			o_distance  <= 9'h0;
		end else begin
			case (st_q)
			pct_pkg::CS_IDLE: begin
				if (i_start) begin
					st_q        <= pct_pkg::CS_SILENCE;
					tmr_q       <= 32'h0;
					o_busy      <= 1'b1;
					o_quiet_req <= 1'b1;
				end
			end
			pct_pkg::CS_SILENCE: begin
				if (i_partner_quiet) begin
					st_q    <= pct_pkg::CS_PULSE;
					tmr_q   <= 32'h0;
					o_pulse <= 1'b1;
				end else if (tmr_q == 32'(SILENCE_CYC - 1)) begin
					// Foreign energy would be mistaken for an echo
					o_result    <= pct_pkg::CT_INVALID;
					o_distance  <= 9'h0;
					o_busy      <= 1'b0;
					o_quiet_req <= 1'b0;
					st_q        <= pct_pkg::CS_IDLE;
				end else begin
					tmr_q <= tmr_q + 32'h1;
				end
			end
			pct_pkg::CS_PULSE: begin
				// Fixed width pulse onto the chosen pair
				if (tmr_q == 32'(pct_pkg::TDR_PULSE_CYC - 1)) begin
					o_pulse <= 1'b0;
					dcnt_q  <= 9'h0;
					st_q    <= pct_pkg::CS_LISTEN;
				end else begin
					tmr_q <= tmr_q + 32'h1;
				end
			end
			pct_pkg::CS_LISTEN: begin
				// Delay to the echo is the distance count
				if (i_echo_seen || dcnt_q == pct_pkg::DIST_MAX) begin
					o_result    <= !i_echo_seen ? pct_pkg::CT_NORMAL :
						i_echo_short ? pct_pkg::CT_SHORT :
						pct_pkg::CT_OPEN;
					o_distance  <= dcnt_q;
					o_busy      <= 1'b0;
					o_quiet_req <= 1'b0;
					st_q        <= pct_pkg::CS_IDLE;
				end else begin
					dcnt_q <= dcnt_q + 9'h1;
				end
			end
			default: begin
				st_q <= pct_pkg::CS_IDLE;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

// file: src/pct_top.sv
// Purpose: Cable test, connectivity chain and power modes behind MDC/MDIO
// Assumes: MDC and all pins are asynchronous to i_clk_sys
// Notes:   MDC must stay well below a quarter of the system clock
`timescale 1ns/1ps
`default_nettype none
module pct_top #(
	parameter int unsigned SILENCE_CYC = pct_pkg::SILENCE_CYC,
	parameter int unsigned LP_CYC      = pct_pkg::LP_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_mdc,
	input  wire logic       i_mdio,
	output logic            o_mdio_out,
	output logic            o_mdio_oe,
	input  wire logic [2:0] i_strap_phy_address,
	input  wire logic       i_rxd1,
	input  wire logic       i_rxd0,
	input  wire logic       i_crs_dv,
	input  wire logic       i_ref_clk,
	input  wire logic       i_interrupt_out_pin,
	input  wire logic       i_txen,
	input  wire logic       i_status_light_out_0,
	input  wire logic       i_txd0,
	input  wire logic       i_link_up,
	input  wire logic       i_partner_quiet,
	input  wire logic       i_echo_seen,
	input  wire logic       i_echo_short,
	output logic            o_nand_out,
	output logic            o_nand_mode,
	output logic            o_quiet_req,
	output logic            o_tdr_pulse,
	output logic            o_pwr_save,
	output logic            o_energy_detect_power_down_active,
	output logic            o_pll_stop,
	output logic            o_power_down,
	output logic            o_slow_osc,
	output logic            o_mdix_forced,
	output logic            o_pair_crossed,
	output logic            o_link_pulse
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 15;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;
	logic [10:0]      chain;

	// Bits 0..9 are the chain inputs in test order
	assign pin_raw = {i_strap_phy_address, i_echo_short, i_echo_seen,
		i_txd0, i_status_light_out_0, i_txen, i_interrupt_out_pin,
		i_ref_clk, i_crs_dv, i_rxd0, i_rxd1, i_mdc, i_mdio};

	// Two stages per pin; chain inputs feed NAND stage by stage
	assign chain[0] = 1'b1;
	genvar g;
	generate
		for (g = 0; g < NSYNC; g++) begin : g_sync
			always_ff @(posedge i_clk_sys) begin
				meta_q[g] <= pin_raw[g];
				sync_q[g] <= meta_q[g];
			end
		end
		for (g = 0; g < 10; g++) begin : g_chain
			// A low input forces its stage high, so each flips the end
			assign chain[g+1] = ~(sync_q[g] & chain[g]);
		end
	endgenerate

	logic mdio_s;
	logic mdc_s;
	logic mdc_prev_q;
	logic mdc_rise;
	assign mdio_s   = sync_q[0];
	assign mdc_s    = sync_q[1];
	assign mdc_rise = mdc_s & ~mdc_prev_q;

	// ----------------------------------------------------------------
	// Address strap capture
	// ----------------------------------------------------------------
	logic [2:0] strap_q;
	logic       strap_done_q;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			strap_q      <= 3'h0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_q      <= sync_q[14:12];
			strap_done_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register bits
	// ----------------------------------------------------------------
	logic an_en_q, pd_q, pll_off_q, slow_osc_q, bcast_off_q;
	logic nand_en_q, energy_detect_power_down_dis_q, mdix_sel_q, amdix_dis_q, pwr_save_q;
	logic       wr_stb_q;
	logic [4:0] reg_addr_q;
	logic [15:0] wr_data_q;
	logic       ct_start_q;
	logic       ct_busy;
	logic [1:0] ct_result;
	logic [8:0] ct_dist;

	// Soft reset restores every default and reads back as zero
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || (wr_stb_q && reg_addr_q == pct_pkg::REG_BASIC_CTRL
			&& wr_data_q[pct_pkg::BIT_SW_RESET])) begin
			an_en_q     <= pct_pkg::RST_AN_EN;
			pd_q        <= 1'b0;
			pll_off_q   <= 1'b0;
			slow_osc_q  <= 1'b0;
			bcast_off_q <= 1'b0;
			nand_en_q   <= 1'b0;
			energy_detect_power_down_dis_q  <= pct_pkg::RST_ENERGY_DETECT_POWER_DOWN_DIS;
			mdix_sel_q  <= 1'b0;
			amdix_dis_q <= 1'b0;
			pwr_save_q  <= 1'b0;
		end else if (wr_stb_q) begin
			case (reg_addr_q)
			pct_pkg::REG_BASIC_CTRL: begin
				an_en_q <= wr_data_q[pct_pkg::BIT_AN_EN];
				pd_q    <= wr_data_q[pct_pkg::BIT_PWR_DOWN];
			end
			pct_pkg::REG_DIGI_CTRL:
				pll_off_q <= wr_data_q[pct_pkg::BIT_PLL_OFF];
			pct_pkg::REG_AFE_CTRL:
				slow_osc_q <= wr_data_q[pct_pkg::BIT_SLOW_OSC];
			pct_pkg::REG_OPMODE_OVR: begin
				bcast_off_q <= wr_data_q[pct_pkg::BIT_BCAST_OFF];
				nand_en_q   <= wr_data_q[pct_pkg::BIT_NAND_EN];
			end
			pct_pkg::REG_EXP_CTRL:
				energy_detect_power_down_dis_q <= wr_data_q[pct_pkg::BIT_ENERGY_DETECT_POWER_DOWN_DIS];
			pct_pkg::REG_PHY_CTRL2: begin
				mdix_sel_q  <= wr_data_q[pct_pkg::BIT_MDIX_SEL];
				amdix_dis_q <= wr_data_q[pct_pkg::BIT_AMDIX_DIS];
				pwr_save_q  <= wr_data_q[pct_pkg::BIT_PWR_SAVE];
			end
			default: begin
			end
			endcase
		end
	end

	// Run launch; ignored while running or powered down
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ct_start_q <= 1'b0;
		end else begin
			ct_start_q <= wr_stb_q && reg_addr_q == pct_pkg::REG_CABLE_TEST
				&& wr_data_q[pct_pkg::BIT_CT_START] && !ct_busy
				&& !ct_start_q && !pd_q;
		end
	end

	// Read view; start bit shows the run in flight
	logic [15:0] rdata;
	always_comb begin
		rdata = 16'h0;
		case (reg_addr_q)
		pct_pkg::REG_BASIC_CTRL: begin
			rdata[pct_pkg::BIT_AN_EN]    = an_en_q;
			rdata[pct_pkg::BIT_PWR_DOWN] = pd_q;
		end
		pct_pkg::REG_DIGI_CTRL:  rdata[pct_pkg::BIT_PLL_OFF]  = pll_off_q;
		pct_pkg::REG_AFE_CTRL:   rdata[pct_pkg::BIT_SLOW_OSC] = slow_osc_q;
		pct_pkg::REG_OPMODE_OVR: begin
			rdata[pct_pkg::BIT_BCAST_OFF] = bcast_off_q;
			rdata[pct_pkg::BIT_NAND_EN]   = nand_en_q;
		end
		pct_pkg::REG_EXP_CTRL:   rdata[pct_pkg::BIT_ENERGY_DETECT_POWER_DOWN_DIS] = energy_detect_power_down_dis_q;
		pct_pkg::REG_CABLE_TEST: begin
			rdata[pct_pkg::BIT_CT_START] = ct_busy | ct_start_q;
			rdata[pct_pkg::CT_RES_LSB +: 2] = ct_result;
			rdata[pct_pkg::CT_DIST_MSB:0]   = ct_dist;
		end
		pct_pkg::REG_PHY_CTRL2: begin
			rdata[pct_pkg::BIT_MDIX_SEL]  = mdix_sel_q;
			rdata[pct_pkg::BIT_AMDIX_DIS] = amdix_dis_q;
			rdata[pct_pkg::BIT_PWR_SAVE]  = pwr_save_q;
		end
		default: rdata = 16'h0;
		endcase
	end

	// ----------------------------------------------------------------
	// Management frame engine
	// ----------------------------------------------------------------
	pct_pkg::pct_mstate_t mst_q;
	logic [5:0]  ones_q;
	logic [4:0]  cnt_q;
	logic [15:0] sh_q;
	logic [15:0] sh_n;
	logic        addr_hit;
	assign sh_n     = {sh_q[14:0], mdio_s};
	assign addr_hit = (sh_n[9:5] == {2'h0, strap_q})
		|| (sh_n[9:5] == 5'h0 && !bcast_off_q);

	// Bits are taken on MDC rise; read data changes just after a rise
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			mst_q      <= pct_pkg::MS_IDLE;
			mdc_prev_q <= 1'b1; // Idle MDC is high: no false rise
			ones_q     <= 6'h0;
			cnt_q      <= 5'h0;
			sh_q       <= 16'h0;
			reg_addr_q <= 5'h0;
			wr_stb_q   <= 1'b0;
			wr_data_q  <= 16'h0;
			o_mdio_out <= 1'b0;
			o_mdio_oe  <= 1'b0;
		end else begin
			mdc_prev_q <= mdc_s;
			wr_stb_q   <= 1'b0;
			if (mdc_rise) begin
				case (mst_q)
				pct_pkg::MS_IDLE: begin
					cnt_q <= 5'h0;
					if (mdio_s) begin
						if (ones_q != pct_pkg::PREAMBLE_LEN)
							ones_q <= ones_q + 6'h1;
					end else begin
						ones_q <= 6'h0;
						if (ones_q == pct_pkg::PREAMBLE_LEN)
							mst_q <= pct_pkg::MS_HDR;
					end
				end
				pct_pkg::MS_HDR: begin
					sh_q  <= sh_n;
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q == pct_pkg::HDR_LAST) begin
						reg_addr_q <= sh_n[4:0];
						cnt_q      <= 5'h0;
						if (!sh_n[12] || !addr_hit)
							mst_q <= pct_pkg::MS_IDLE;
						else if (sh_n[11:10] == pct_pkg::OP_READ)
							mst_q <= pct_pkg::MS_TA;
						else if (sh_n[11:10] == pct_pkg::OP_WRITE)
							mst_q <= pct_pkg::MS_WTA;
						else
							mst_q <= pct_pkg::MS_IDLE;
					end
				end
				pct_pkg::MS_TA: begin
					o_mdio_oe  <= 1'b1;
					o_mdio_out <= 1'b0;
					sh_q       <= rdata;
					mst_q      <= pct_pkg::MS_RD;
				end
				pct_pkg::MS_RD: begin
					if (cnt_q == pct_pkg::DATA_BITS) begin
						o_mdio_oe <= 1'b0;
						mst_q     <= pct_pkg::MS_IDLE;
					end else begin
						o_mdio_out <= sh_q[15];
						sh_q       <= {sh_q[14:0], 1'b0};
						cnt_q      <= cnt_q + 5'h1;
					end
				end
				pct_pkg::MS_WTA: begin
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q != 5'h0) begin
						cnt_q <= 5'h0;
						mst_q <= pct_pkg::MS_WR;
					end
				end
				pct_pkg::MS_WR: begin
					sh_q  <= sh_n;
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q == pct_pkg::DATA_LAST) begin
						wr_data_q <= sh_n;
						wr_stb_q  <= 1'b1;
						mst_q     <= pct_pkg::MS_IDLE;
					end
				end
				default: mst_q <= pct_pkg::MS_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Cable run sequencer
	// ----------------------------------------------------------------
	pct_cable_engine #(
		.SILENCE_CYC(SILENCE_CYC)
	) u_engine (
		.i_clk_sys      (i_clk_sys),
		.i_rst_n        (i_rst_n),
		.i_start        (ct_start_q),
		.i_partner_quiet(i_partner_quiet),
		.i_echo_seen    (sync_q[10]),
		.i_echo_short   (sync_q[11]),
		.o_busy         (ct_busy),
		.o_quiet_req    (o_quiet_req),
		.o_pulse        (o_tdr_pulse),
		.o_result       (ct_result),
		.o_distance     (ct_dist)
	);

	// ----------------------------------------------------------------
	// Power modes, pair forcing and chain output
	// ----------------------------------------------------------------
	logic        idle_link;
	logic [31:0] lp_cnt_q;
	assign idle_link = an_en_q & ~i_link_up & ~pd_q;

	// Registered so every mode pin is glitch free
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_pwr_save     <= 1'b0;
			o_energy_detect_power_down_active  <= 1'b0;
			o_pll_stop     <= 1'b0;
			o_power_down   <= 1'b0;
			o_slow_osc     <= 1'b0;
			o_mdix_forced  <= 1'b0;
			o_pair_crossed <= 1'b0;
			o_nand_mode    <= 1'b0;
			o_nand_out     <= 1'b0;
		end else begin
			o_pwr_save     <= pwr_save_q & idle_link;
			o_energy_detect_power_down_active  <= ~energy_detect_power_down_dis_q & idle_link;
			o_pll_stop     <= ~energy_detect_power_down_dis_q & idle_link & pll_off_q;
			o_power_down   <= pd_q;
			o_slow_osc     <= slow_osc_q;
			o_mdix_forced  <= amdix_dis_q;
			o_pair_crossed <= amdix_dis_q & ~mdix_sel_q;
			o_nand_mode    <= nand_en_q;
			o_nand_out     <= nand_en_q & chain[10];
		end
	end

	// Wake-up pulses so two sleeping ends can still find each other
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_energy_detect_power_down_active) begin
			lp_cnt_q     <= 32'h0;
			o_link_pulse <= 1'b0;
		end else begin
			o_link_pulse <= (lp_cnt_q == 32'(LP_CYC - 1));
			lp_cnt_q     <= (lp_cnt_q == 32'(LP_CYC - 1)) ? 32'h0 :
				lp_cnt_q + 32'h1;
		end
	end

endmodule
`default_nettype wire

// file: test/pct_top_assertions.sv
// Purpose: Port-level checks on the cable test and power block
// Assumes: One system clock domain, synchronous active-low reset
// Notes:   Link pulse spacing is tracked by a small gap counter
`timescale 1ns/1ps
`default_nettype none
module pct_top_checker #(
	parameter int unsigned LP_CYC = 20
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_link_up,
	input wire logic i_partner_quiet,
	input wire logic o_nand_out,
	input wire logic o_nand_mode,
	input wire logic o_quiet_req,
	input wire logic o_tdr_pulse,
	input wire logic o_pwr_save,
	input wire logic o_energy_detect_power_down_active,
	input wire logic o_pll_stop,
	input wire logic o_power_down,
	input wire logic o_mdix_forced,
	input wire logic o_pair_crossed,
	input wire logic o_link_pulse
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic [31:0] gap_q;
	logic        seen_q;
	// Gap since last link pulse; forgotten outside low-power state
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || !o_energy_detect_power_down_active) begin
			gap_q <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			gap_q <= o_link_pulse ? 32'h1 : gap_q + 32'h1;
			seen_q <= seen_q | o_link_pulse;
		end
	end
	AST_NAND_GATED: assert property (!o_nand_mode && !$past(o_nand_mode)
		|-> !o_nand_out) else $error("chain output while mode off");
	AST_PULSE_WIDTH: assert property ($rose(o_tdr_pulse) |->
		o_tdr_pulse[*4] ##1 !o_tdr_pulse) else $error("pulse width");
	AST_PULSE_QUIET: assert property ($rose(o_tdr_pulse) |-> o_quiet_req
		&& $past(i_partner_quiet)) else $error("pulse w/o quiet");
	AST_LINK_NO_SAVE: assert property (i_link_up |=> !o_pwr_save &&
		!o_energy_detect_power_down_active) else $error("low power with link");
	AST_PLL_IN_ENERGY_DETECT_POWER_DOWN: assert property (o_pll_stop |-> o_energy_detect_power_down_active ||
		$past(o_energy_detect_power_down_active)) else $error("pll stop outside");
	AST_LP_SINGLE: assert property (o_link_pulse |=> !o_link_pulse)
		else $error("link pulse too long");
	AST_LP_PERIOD: assert property (o_link_pulse && seen_q && o_energy_detect_power_down_active
		|-> gap_q == LP_CYC) else $error("link pulse spacing");
	AST_PWRDN_ALL_OFF: assert property (o_power_down && $past(o_power_down)
		|-> !o_pwr_save && !o_energy_detect_power_down_active && !o_tdr_pulse)
		else $error("activity in power-down");
	AST_CROSS_FORCED: assert property (o_pair_crossed |-> o_mdix_forced)
		else $error("pairs forced while auto");
endmodule
bind pct_top pct_top_checker #(.LP_CYC(LP_CYC)) u_chk (
	.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_link_up(i_link_up),
	.i_partner_quiet(i_partner_quiet), .o_nand_out(o_nand_out),
	.o_nand_mode(o_nand_mode), .o_quiet_req(o_quiet_req),
	.o_tdr_pulse(o_tdr_pulse), .o_pwr_save(o_pwr_save),
	.o_energy_detect_power_down_active(o_energy_detect_power_down_active), .o_pll_stop(o_pll_stop),
	.o_power_down(o_power_down), .o_mdix_forced(o_mdix_forced),
	.o_pair_crossed(o_pair_crossed), .o_link_pulse(o_link_pulse));
`default_nettype wire

// file: test/pct_mgmt_model.sv
// Purpose: Management controller model issuing MDC/MDIO frames
// Assumes: MDC of 160 ns built from 16 system clocks
// Notes:   MDC rests high and MDIO is released between frames
`timescale 1ns/1ps
`default_nettype none
module pct_mgmt_model (
	input  wire logic i_clk_sys,
	input  wire logic i_mdio,
	output logic      o_mdc,
	output logic      o_mdio_out,
	output logic      o_mdio_oe
);
	// Idle: clock still, line left to the pull-up
	initial begin
		o_mdc = 1'b1;
		o_mdio_out = 1'b0;
		o_mdio_oe = 1'b0;
	end
	// One frame; read data is taken at the MDC rise
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] rg, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hffffffff, 2'h1, op, phy, rg, 2'h2, wd};
		rd = 16'h0000;
		@(posedge i_clk_sys);
		#1;
		for (int i = 63; i >= 0; i--) begin
			o_mdc = 1'b0;
			o_mdio_oe = !(op == pct_pkg::OP_READ && i < 18);
			o_mdio_out = f[i];
			repeat (8) @(posedge i_clk_sys);
			if (i < 16)
				rd[i] = i_mdio;
			#1;
			o_mdc = 1'b1;
			repeat (8) @(posedge i_clk_sys);
			#1;
		end
		repeat (8) @(posedge i_clk_sys);
		#1;
		o_mdio_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/tb_phy_cable_test_and_power_modes.sv
// Purpose: Self-checking bench for the cable test and power block
// Assumes: Strap address 3, so frames use management address 03h
// Notes:   Shortened silence and link pulse counts keep the run short
`timescale 1ns/1ps
`default_nettype none
module tb_phy_cable_test_and_power_modes;
	localparam logic [4:0] PHY = 5'h03;
	logic       clk, rst_n, link_up, quiet_en, echo_en, short_en, ph_q;
	logic [9:0] pin_q;
	logic [7:0] echo_n, ecnt_q;
	logic       p_mdc, p_out, p_oe, d_out, d_oe, nand_out, nand_mode;
	logic       quiet_req, tdr_pulse, pwr_save, energy_detect_power_down, pll_stop;
	logic       power_down, slow_osc, mdix_forced, pair_crossed, link_pulse;
	int         n_fail = 0;
	int         samples_checked = 0;
	// Shared line with pull-up
	wire logic mdio_w = d_oe ? d_out : (p_oe ? p_out : 1'b1);
	// Front end: echo comes echo_n cycles after the pulse ends
	wire logic quiet_w = quiet_req & quiet_en;
	wire logic echo_w = ph_q & ~tdr_pulse & echo_en & (ecnt_q >= echo_n);
	always @(posedge clk) begin
		if (!rst_n) begin
			ph_q <= 1'b0;
			ecnt_q <= 8'h00;
		end else begin
			ph_q <= quiet_req & (ph_q | tdr_pulse);
			ecnt_q <= tdr_pulse ? 8'h00 : ecnt_q + 8'h01;
		end
	end
	pct_top #(.SILENCE_CYC(2000), .LP_CYC(20)) DUT (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_mdc(p_mdc & pin_q[1]),
		.i_mdio(mdio_w & pin_q[0]), .o_mdio_out(d_out), .o_mdio_oe(d_oe),
		.i_strap_phy_address(3'h3), .i_rxd1(pin_q[2]), .i_rxd0(pin_q[3]),
		.i_crs_dv(pin_q[4]), .i_ref_clk(pin_q[5]),
		.i_interrupt_out_pin(pin_q[6]), .i_txen(pin_q[7]),
		.i_status_light_out_0(pin_q[8]), .i_txd0(pin_q[9]),
		.i_link_up(link_up), .i_partner_quiet(quiet_w),
		.i_echo_seen(echo_w), .i_echo_short(short_en),
		.o_nand_out(nand_out), .o_nand_mode(nand_mode),
		.o_quiet_req(quiet_req), .o_tdr_pulse(tdr_pulse),
		.o_pwr_save(pwr_save), .o_energy_detect_power_down_active(energy_detect_power_down), .o_pll_stop(pll_stop),
		.o_power_down(power_down), .o_slow_osc(slow_osc),
		.o_mdix_forced(mdix_forced), .o_pair_crossed(pair_crossed),
		.o_link_pulse(link_pulse));
	pct_mgmt_model u_mgmt (.i_clk_sys(clk), .i_mdio(mdio_w),
		.o_mdc(p_mdc), .o_mdio_out(p_out), .o_mdio_oe(p_oe));
	task automatic complete_run();
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
			n_fail++;
		end
	endtask
	task automatic chk1(input logic s, input logic e);
		chk({15'h0000, s}, {15'h0000, e});
	endtask
	task automatic wr(input logic [4:0] r, input logic [15:0] d);
		logic [15:0] x;
		u_mgmt.xfer(pct_pkg::OP_WRITE, PHY, r, d, x);
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [4:0] r, output logic [15:0] d);
		u_mgmt.xfer(pct_pkg::OP_READ, PHY, r, 16'h0000, d);
		repeat (8) @(posedge clk);
		#1;
	endtask
	// Poll start bit with a bounded count
	task automatic poll(output logic [15:0] v);
		int k;
		k = 0;
		rd(pct_pkg::REG_CABLE_TEST, v);
		while (v[15] !== 1'b0 && k < 20) begin
			rd(pct_pkg::REG_CABLE_TEST, v);
			k++;
		end
		if (v[15] !== 1'b0) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic run(output logic [15:0] v);
		wr(pct_pkg::REG_CABLE_TEST, 16'h8000);
		poll(v);
	endtask
	task automatic t_reset();
		logic [15:0] v;
		rd(pct_pkg::REG_BASIC_CTRL, v);
		chk(v, 16'h1000);
		rd(pct_pkg::REG_EXP_CTRL, v);
		chk(v, 16'h0800);
		rd(pct_pkg::REG_PHY_CTRL2, v);
		chk(v, 16'h0000);
		rd(pct_pkg::REG_CABLE_TEST, v);
		chk(v, 16'h0000);
		wr(5'h02, 16'h5a5a);
		rd(5'h02, v);
		chk(v, 16'h0000);
		// Foreign address: nobody answers, pull-up reads ones
		u_mgmt.xfer(pct_pkg::OP_READ, 5'h05, 5'h00, 16'h0000, v);
		chk(v, 16'hffff);
		// Broadcast address answers by default
		u_mgmt.xfer(pct_pkg::OP_READ, 5'h00, pct_pkg::REG_EXP_CTRL,
			16'h0000, v);
		chk(v, 16'h0800);
		chk1(pwr_save | energy_detect_power_down, 1'b0);
	endtask
	task automatic t_cable();
		logic [15:0] v;
		logic [8:0]  d1;
		wr(pct_pkg::REG_PHY_CTRL2, 16'h2000);
		chk1(mdix_forced & pair_crossed, 1'b1);
		wr(pct_pkg::REG_PHY_CTRL2, 16'h6000);
		chk1(pair_crossed, 1'b0);
		wr(pct_pkg::REG_CABLE_TEST, 16'h8000);
		rd(pct_pkg::REG_CABLE_TEST, v);
		chk1(v[15], 1'b1);
		poll(v);
		chk(v & 16'he1ff, 16'h6000);
		wr(pct_pkg::REG_CABLE_TEST, 16'h0000);
		rd(pct_pkg::REG_CABLE_TEST, v);
		chk(v & 16'he1ff, 16'h6000);
		quiet_en = 1'b1;
		run(v);
		chk(v & 16'he1ff, 16'h01ff);
		echo_en = 1'b1;
		echo_n = 8'h0a;
		run(v);
		chk(v & 16'he000, 16'h2000);
		d1 = v[8:0];
		short_en = 1'b1;
		echo_n = 8'h28;
		run(v);
		chk(v & 16'he000, 16'h4000);
		chk({7'h00, v[8:0] - d1}, 16'h001e);
	endtask
	task automatic t_chain();
		logic [15:0] v;
		wr(pct_pkg::REG_OPMODE_OVR, 16'h0020);
		chk1(nand_mode, 1'b1);
		chk1(nand_out, 1'b1);
		for (int i = 0; i < 10; i++) begin
			pin_q = 10'h3ff << (i + 1);
			repeat (8) @(posedge clk);
			#1;
			chk1(nand_out, i[0]);
		end
		pin_q = 10'h3ff;
		repeat (8) @(posedge clk);
		#1;
		chk1(nand_out, 1'b1);
		wr(pct_pkg::REG_OPMODE_OVR, 16'h0200);
		chk1(nand_out, 1'b0);
		// Broadcast turned off: address 0 no longer answers
		u_mgmt.xfer(pct_pkg::OP_READ, 5'h00, pct_pkg::REG_OPMODE_OVR,
			16'h0000, v);
		chk(v, 16'hffff);
		rd(pct_pkg::REG_OPMODE_OVR, v);
		chk(v, 16'h0200);
	endtask
	task automatic t_power();
		int          k;
		logic [15:0] v;
		wr(pct_pkg::REG_PHY_CTRL2, 16'h2400);
		chk1(pwr_save, 1'b1);
		wr(pct_pkg::REG_EXP_CTRL, 16'h0000);
		chk1(energy_detect_power_down, 1'b1);
		wr(pct_pkg::REG_DIGI_CTRL, 16'h0010);
		chk1(pll_stop, 1'b1);
		k = 0;
		while (link_pulse !== 1'b1 && k < 40) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk1(link_pulse, 1'b1);
		if (link_pulse !== 1'b1)
			complete_run();
		link_up = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk1(pwr_save | energy_detect_power_down | pll_stop, 1'b0);
		link_up = 1'b0;
		wr(pct_pkg::REG_BASIC_CTRL, 16'h1800);
		chk1(power_down, 1'b1);
		chk1(energy_detect_power_down | pwr_save, 1'b0);
		wr(pct_pkg::REG_CABLE_TEST, 16'h8000);
		rd(pct_pkg::REG_CABLE_TEST, v);
		chk1(v[15], 1'b0);
		wr(pct_pkg::REG_AFE_CTRL, 16'h0020);
		chk1(slow_osc, 1'b1);
		wr(pct_pkg::REG_AFE_CTRL, 16'h0000);
		chk1(slow_osc, 1'b0);
		wr(pct_pkg::REG_BASIC_CTRL, 16'h1000);
		chk1(power_down, 1'b0);
		wr(pct_pkg::REG_BASIC_CTRL, 16'h8000);
		rd(pct_pkg::REG_EXP_CTRL, v);
		chk(v, 16'h0800);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (99000) @(posedge clk);
		n_fail++;
		complete_run();
	end
	initial begin
		rst_n = 1'b0;
		pin_q = 10'h3ff;
		link_up = 1'b0;
		quiet_en = 1'b0;
		echo_en = 1'b0;
		short_en = 1'b0;
		echo_n = 8'h00;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		t_cable();
		t_chain();
		t_power();
		complete_run();
	end
endmodule
`default_nettype wire
